// [hdl/flow_through_sync_sram_port.sv]
// Flow-through synchronous SRAM port with burst counter and byte writes.
// Assumes the memory controller runs on clk_sys; sleep, order select and
// output drive come from pins and are treated as asynchronous.
//
// Overview of operation
// - Address captured on load, enabled, fully selected
// - Lowest two address bits seed burst counter
// - Byte enables ignored on a load with write select high
// - Enabled lanes written, committed when no read needs the array
// - Each byte enable governs only its lane
// - Clock enable high freezes all but the pin synchronisers
// - Load write select sets whole burst direction
// - Data moves one cycle after its command
// - Everything synchronous uses rising clock edge
// - Load with any select inactive deselects
// - Data bus floats one cycle after deselect
// - Second chip select is active high
// - Output drive high floats data at once
// - Selected load starts a new operation
// - Advance steps counter, ignores address, direction
// - Order select high interleaved, low linear
// - Sleep request enters standby
// - Two-bit counter gives four beats
// - Deselect ends burst, pending transfer completes
// - Input and output data are registered
`include "sram_port_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module flow_through_sync_sram_port #(
    parameter int ADDR_W = `SRAM_ADDR_W,
    parameter int LANES = `SRAM_LANES,
    parameter int LANE_W = `SRAM_LANE_W,
    parameter int BUF_DEPTH = `SRAM_BUF_DEPTH
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Address
    input wire logic [ADDR_W-3:0] addrHigh,
    input wire logic addr_lsb0,
    input wire logic addr_lsb1,
    // Synchronous control
    input wire logic advance_load_n,
    input wire logic write_select_n,
    input wire logic clock_enable_n,
    input wire logic chip_select1_n,
    input wire logic chip_select2,
    input wire logic chip_select3_n,
    // Byte write enables, lane 0 to 3
    input wire logic byte_write_n_0,
    input wire logic byte_write_n_1,
    input wire logic byte_write_n_2,
    input wire logic byte_write_n_3,
    // Data pins, split into in, out and enable
    input wire logic [LANES*LANE_W-1:0] dataIn,
    output logic [LANES*LANE_W-1:0] dataOut,
    output logic dataOe_n,
    // Asynchronous and static pins
    input wire logic output_drive_n,
    input wire logic sleep_request,
    input wire logic burstOrderSelect,
    // Status
    output logic sleepActive
);

    localparam int WORD_W = LANES * LANE_W;
    localparam int ENT_W = ADDR_W + WORD_W + LANES;
    localparam int BW = `SRAM_BURST_W;
    localparam int SYNC_N = `SRAM_SYNC_STAGES;

    // Refuse widths the byte lanes and counter cannot serve
    if (ADDR_W < BW + 1 || ADDR_W > 24 || LANES != 4 || LANE_W < 1)
    begin : g_check
        $error("flow_through_sync_sram_port: unsupported parameters");
    end

    // Burst address bits for a beat in the chosen order
    function automatic logic [BW-1:0] burstLsb(
        input logic [BW-1:0] start,
        input logic [BW-1:0] beat,
        input sram_port_pkg::order_t order
    );
        if (order == sram_port_pkg::ORDER_INTERLEAVED) begin
            return start ^ beat;
        end
        return BW'(start + beat);
    endfunction

    // Replace enabled lanes of a word with new data
    function automatic logic [WORD_W-1:0] mergeLanes(
        input logic [WORD_W-1:0] old,
        input logic [WORD_W-1:0] fresh,
        input logic [LANES-1:0] mask
    );
        logic [WORD_W-1:0] res;
        res = old;
        for (int l = 0; l < LANES; l++) begin
            if (mask[l]) begin
                res[l*LANE_W +: LANE_W] = fresh[l*LANE_W +: LANE_W];
            end
        end
        return res;
    endfunction

    // Storage array
    logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];

    // Pin synchronisers
    logic [SYNC_N-1:0] sleepSync;
    logic [SYNC_N-1:0] orderSync;
    sram_port_pkg::order_t burstOrder;

    // Burst state
    logic burstActive;
    logic burstWrite;
    logic [ADDR_W-3:0] burstBase;
    logic [BW-1:0] burstStart;
    logic [BW-1:0] beatIdx;

    // Data phase state
    sram_port_pkg::phase_t phase;
    logic [ADDR_W-1:0] phaseAddr;
    logic [LANES-1:0] phaseMask;

    // Command decode
    logic ce;
    logic selected;
    logic newOp;
    logic deselect;
    logic advCyc;
    logic cmdValid;
    logic cmdWrite;
    logic [ADDR_W-1:0] cmdAddr;
    logic [LANES-1:0] laneEn;
    logic [LANES-1:0] cmdMask;
    logic [WORD_W-1:0] readView;

    // Commit buffer
    logic pushValid;
    logic bufInReady;
    logic drainReady;
    logic drainValid;
    logic [ENT_W-1:0] drainEnt;
    logic [BUF_DEPTH*ENT_W-1:0] peekData;
    logic [BUF_DEPTH-1:0] peekValid;
    logic bufFull;
    logic drainFire;

    // Sleep request passes two flops before use
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sleepSync <= '0;
        end else begin
            sleepSync <= {sleepSync[SYNC_N-2:0], sleep_request};
        end
    end

    // Order select, static, still synchronised
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            orderSync <= '1;
        end else begin
            orderSync <= {orderSync[SYNC_N-2:0], burstOrderSelect};
        end
    end

    // Standby and burst order from synchronised pins
    assign sleepActive = sleepSync[SYNC_N-1];
    assign burstOrder = orderSync[SYNC_N-1]
        ? sram_port_pkg::ORDER_INTERLEAVED
        : sram_port_pkg::ORDER_LINEAR;

    // Edge qualification and command decode
    assign ce = !clock_enable_n;
    assign selected = !chip_select1_n && chip_select2
        && !chip_select3_n;
    assign newOp = ce && !advance_load_n && selected
        && !sleepActive;
    assign deselect = ce && !advance_load_n && !selected;
    assign advCyc = ce && advance_load_n && burstActive
        && !sleepActive;
    assign cmdValid = newOp || advCyc;
    assign cmdWrite = newOp ? !write_select_n : burstWrite;

    // Address of this beat; advance ignores the address pins
    assign cmdAddr = newOp
        ? {addrHigh, addr_lsb1, addr_lsb0}
        : {burstBase, burstLsb(burstStart, BW'(beatIdx + 1'b1),
                               burstOrder)};

    // Lane enables, each for its own lane, on load and burst beats
    assign laneEn = {!byte_write_n_3, !byte_write_n_2,
                     !byte_write_n_1, !byte_write_n_0};
    assign cmdMask = (cmdValid && cmdWrite) ? laneEn : '0;

    // Burst counter: seeded on load, stepped on advance
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            burstActive <= 1'b0;
            burstWrite <= 1'b0;
            burstBase <= '0;
            burstStart <= '0;
            beatIdx <= '0;
        end else if (newOp) begin
            burstActive <= 1'b1;
            burstWrite <= !write_select_n;
            burstBase <= addrHigh;
            burstStart <= {addr_lsb1, addr_lsb0};
            beatIdx <= '0;
        end else if (deselect) begin
            burstActive <= 1'b0;
        end else if (advCyc) begin
            beatIdx <= BW'(beatIdx + 1'b1);
        end
    end

    // Data phase one cycle behind its command
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phase <= sram_port_pkg::PH_IDLE;
            phaseAddr <= '0;
            phaseMask <= '0;
        end else if (ce) begin
            phaseAddr <= cmdAddr;
            phaseMask <= cmdMask;
            case ({cmdValid, cmdWrite})
                2'b10: phase <= sram_port_pkg::PH_READ;
                2'b11: phase <= sram_port_pkg::PH_WRITE;
                default: phase <= sram_port_pkg::PH_IDLE;
            endcase
        end
    end

    // Read view: array, then queued writes, then the live write beat
    always_comb begin
        logic [ENT_W-1:0] e;
        e = '0;
        readView = mem[cmdAddr];
        for (int i = 0; i < BUF_DEPTH; i++) begin
            e = peekData[i*ENT_W +: ENT_W];
            if (peekValid[i] && e[ENT_W-1 -: ADDR_W] == cmdAddr) begin
                readView = mergeLanes(readView, e[LANES +: WORD_W],
                                      e[LANES-1:0]);
            end
        end
        if (phase == sram_port_pkg::PH_WRITE && phaseAddr == cmdAddr) begin
            readView = mergeLanes(readView, dataIn, phaseMask);
        end
    end

    // Registered read data, held while clock enable is high
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dataOut <= '0;
        end else if (ce && cmdValid && !cmdWrite) begin
            dataOut <= readView;
        end
    end

    // Drive only in a read phase with output drive low
    assign dataOe_n = !(phase == sram_port_pkg::PH_READ
        && !output_drive_n);

    // Write beat data is registered into the commit buffer
    assign pushValid = ce && phase == sram_port_pkg::PH_WRITE;

    // Array writes yield to reads unless the buffer is full
    assign drainReady = ce && (bufFull
        || (!sleepActive && !(cmdValid && !cmdWrite)));
    assign drainFire = drainValid && drainReady;

    sram_skid_buffer #(
        .W(ENT_W),
        .DEPTH(BUF_DEPTH)
    ) u_commit (
        .clk_sys(clk_sys),
        .rst(rst),
        .inValid(pushValid && bufInReady),
        .inReady(bufInReady),
        .inData({phaseAddr, dataIn, phaseMask}),
        .outValid(drainValid),
        .outReady(drainReady),
        .outData(drainEnt),
        .peekData(peekData),
        .peekValid(peekValid),
        .full(bufFull)
    );

    // Commit enabled lanes only
    always_ff @(posedge clk_sys) begin
        if (drainFire) begin
            for (int l = 0; l < LANES; l++) begin
                if (drainEnt[l]) begin
                    mem[drainEnt[ENT_W-1 -: ADDR_W]]
                        [l*LANE_W +: LANE_W]
                        <= drainEnt[LANES + l*LANE_W +: LANE_W];
                end
            end
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    addr_capture_a: assert property (
        newOp |=> burstActive && burstBase == $past(addrHigh)
            && burstStart == $past({addr_lsb1, addr_lsb0})
            && beatIdx == '0)
        else $error("load did not capture the address");

    mask_ignore_a: assert property (
        (ce && !advance_load_n && write_select_n) |=> phaseMask == '0)
        else $error("byte enables used on a read load");

    lane_select_a: assert property (
        (newOp && !write_select_n) |=> phaseMask == $past(laneEn)
            && phase == sram_port_pkg::PH_WRITE)
        else $error("write lanes do not follow byte enables");

    freeze_state_a: assert property (
        clock_enable_n |=> $stable(phase) && $stable(dataOut)
            && $stable(burstActive) && $stable(beatIdx))
        else $error("state moved while clock enable high");

    burst_dir_a: assert property (
        (advCyc && !deselect) |=> phase == (burstWrite
            ? sram_port_pkg::PH_WRITE : sram_port_pkg::PH_READ))
        else $error("burst beat lost its direction");

    read_drive_a: assert property (
        (newOp && write_select_n) ##1 !output_drive_n |-> !dataOe_n)
        else $error("read data not driven one cycle later");

    deselect_float_a: assert property (
        deselect |=> dataOe_n && !burstActive)
        else $error("bus driven after deselect");

    drive_gate_a: assert property (
        output_drive_n |-> dataOe_n)
        else $error("data driven with output drive high");

    beat_step_a: assert property (
        advCyc |=> beatIdx == BW'($past(beatIdx) + 1'b1)
            && $stable(burstBase))
        else $error("burst counter did not step");

    no_overflow_a: assert property (
        pushValid |-> bufInReady ##1 peekValid[0])
        else $error("write beat refused by commit buffer");

    back_to_back_a: assert property (
        (newOp && !write_select_n) ##1 (newOp && write_select_n)
            |=> phase == sram_port_pkg::PH_READ)
        else $error("read after write was delayed");

    // Main scenarios
    read_seen_c: cover property (newOp && write_select_n ##1 !dataOe_n);
    write_seen_c: cover property (drainFire);
    burst_four_c: cover property (newOp ##1 advCyc [*3]);
    buffer_full_c: cover property (bufFull && pushValid);
    turnaround_c: cover property (
        (newOp && !write_select_n) ##1 (newOp && write_select_n));

endmodule

`default_nettype wire

// [shared/sram_port_defines.svh]
// Constants of the synchronous SRAM port: word layout, burst, buffer.
// Assumes nothing; included by bare name from design files.
`ifndef SRAM_PORT_DEFINES_SVH
`define SRAM_PORT_DEFINES_SVH

// Byte lanes and lane width of one data word
`define SRAM_LANES 4
`define SRAM_LANE_W 9

// Address width of the array in words
`define SRAM_ADDR_W 18

// Burst counter width and lowest address bits it replaces
`define SRAM_BURST_W 2

// Entries of the write commit buffer
`define SRAM_BUF_DEPTH 2

// Stages of the pin synchronisers
`define SRAM_SYNC_STAGES 2

`endif

// [shared/sram_port_pkg.sv]
// Types shared by the SRAM port design files.
// Assumes no other package.
package sram_port_pkg;

    // Data phase that follows a sampled command
    typedef enum logic [1:0] {PH_IDLE, PH_READ, PH_WRITE} phase_t;

    // Burst address order
    typedef enum logic {ORDER_LINEAR, ORDER_INTERLEAVED} order_t;

endpackage

// [hdl/sram_skid_buffer.sv]
// Shift-register buffer with valid/ready on both sides and peek ports.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module sram_skid_buffer #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [W-1:0] inData,
    // Draining side
    output logic outValid,
    input wire logic outReady,
    output logic [W-1:0] outData,
    // Contents, entry 0 oldest
    output logic [DEPTH*W-1:0] peekData,
    output logic [DEPTH-1:0] peekValid,
    output logic full
);

    // Refuse shapes the shift logic cannot serve
    if (DEPTH < 2 || W < 1) begin : g_check
        $error("sram_skid_buffer needs DEPTH >= 2 and W >= 1");
    end

    logic [DEPTH-1:0] vld;
    logic [DEPTH*W-1:0] ent;
    logic push;
    logic pop;
    logic [DEPTH-1:0] slotHot;
    logic [DEPTH-1:0] vldAbove;
    logic [DEPTH-1:0] vldBelow;
    logic [DEPTH*W-1:0] entAbove;

    // Handshakes; a pop frees room for a push in the same cycle
    assign full = vld[DEPTH-1];
    assign inReady = !full || outReady;
    assign outValid = vld[0];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = ent[W-1:0];
    assign peekData = ent;
    assign peekValid = vld;

    // Neighbour views; past the top reads empty, below entry 0 reads filled
    assign vldAbove = {1'b0, vld[DEPTH-1:1]};
    assign vldBelow = {vld[DEPTH-2:0], 1'b1};
    assign entAbove = {ent[DEPTH*W-1 -: W], ent[DEPTH*W-1:W]};

    // One-hot slot that a push fills, after any pop
    always_comb begin
        slotHot = '0;
        for (int i = 0; i < DEPTH; i++) begin
            if (pop ? vld[i] && !vldAbove[i] : !vld[i] && vldBelow[i]) begin
                slotHot[i] = push;
            end
        end
    end

    // Valid bits shift down on pop, set on push
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            vld <= '0;
        end else begin
            vld <= (pop ? {1'b0, vld[DEPTH-1:1]} : vld) | slotHot;
        end
    end

    // Entry storage follows the valid bits
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (slotHot[i]) begin
                ent[i*W +: W] <= inData;
            end else if (pop) begin
                ent[i*W +: W] <= entAbove[i*W +: W];
            end
        end
    end

endmodule

`default_nettype wire

// [tb/sram_ctrl_model.sv]
// Memory controller model that drives every pin of the SRAM port.
// Assumes the bench calls issue once per cycle; pins change at falling edge.
`timescale 1ns/1ps
`default_nettype none

module sram_ctrl_model (
    // Clock
    input wire logic clk_sys,
    // Command pins
    output logic [15:0] addrHigh,
    output logic addr_lsb0,
    output logic addr_lsb1,
    output logic advance_load_n,
    output logic write_select_n,
    output logic clock_enable_n,
    output logic chip_select1_n,
    output logic chip_select2,
    output logic chip_select3_n,
    output logic [3:0] byteWriteN,
    // Data pins
    output logic [35:0] dataIn,
    input wire logic [35:0] dataOut,
    input wire logic dataOe_n,
    // Asynchronous and static pins
    output logic output_drive_n,
    output logic sleep_request,
    output logic burstOrderSelect
);
    logic [35:0] obsData;
    logic obsOe_n;
    logic pendWr;
    logic burstWr;
    logic [35:0] pendData;

    // Idle pins: clock enable off until the first command
    initial begin
        {addrHigh, addr_lsb1, addr_lsb0} = 18'h00000;
        advance_load_n = 1'b1;
        write_select_n = 1'b1;
        clock_enable_n = 1'b1;
        {chip_select1_n, chip_select2, chip_select3_n} = 3'h2;
        byteWriteN = 4'hf;
        dataIn = 36'h000000000;
        output_drive_n = 1'b0;
        sleep_request = 1'b0;
        burstOrderSelect = 1'b1;
        pendWr = 1'b0;
        burstWr = 1'b0;
        pendData = 36'h000000000;
    end

    // One bus cycle: take the last answer, then present command and data
    // Kinds: 0 read, 1 write, 2 advance, 3 deselect, 4 stall
    task automatic issue(input logic [2:0] kind, input logic [17:0] addr,
            input logic [3:0] ben, input logic [35:0] wd,
            input logic [2:0] dsel);
        @(negedge clk_sys);
        obsData = dataOut;
        obsOe_n = dataOe_n;
        clock_enable_n = (kind == 3'h4);
        if (kind != 3'h4) begin
            // Write data one cycle after its command, else a moving pattern
            dataIn = pendWr ? pendData : ~dataIn;
            advance_load_n = (kind == 3'h2);
            {addrHigh, addr_lsb1, addr_lsb0} = addr;
            byteWriteN = ben;
            chip_select1_n = dsel[0];
            chip_select2 = ~dsel[1];
            chip_select3_n = dsel[2];
            // On an advance the direction pin shows the wrong way
            write_select_n = (kind == 3'h0) || (kind == 3'h2 && burstWr);
            pendWr = (kind == 3'h1) || (kind == 3'h2 && burstWr);
            pendData = wd;
            if (kind != 3'h2)
                burstWr = (kind == 3'h1);
        end
    endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// Bench for the SRAM port: lane writes, bursts, stalls, deselects, sleep.
// Assumes the controller model drives all pins, one operation per cycle.
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam logic [2:0] RD = 3'h0;
    localparam logic [2:0] WR = 3'h1;
    localparam logic [2:0] ADV = 3'h2;
    localparam logic [2:0] DES = 3'h3;
    localparam logic [2:0] STL = 3'h4;
    logic clk_sys, rst;
    logic [15:0] addrHigh;
    logic addr_lsb0, addr_lsb1, advance_load_n, write_select_n;
    logic clock_enable_n, chip_select1_n, chip_select2, chip_select3_n;
    logic [3:0] byteWriteN;
    logic [35:0] dataIn, dataOut;
    logic dataOe_n, output_drive_n, sleep_request, burstOrderSelect;
    logic sleepActive;
    int err_total, checked, cycles;
    logic [35:0] mem [logic [17:0]];
    logic expValid, burstOn, burstWr, asleep;
    logic [35:0] expData;
    logic [17:0] burstAddr;
    logic [1:0] beat;

    // Clock at 50 MHz
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    flow_through_sync_sram_port dut_u (
        .clk_sys(clk_sys),
        .rst(rst),
        .addrHigh(addrHigh),
        .addr_lsb0(addr_lsb0),
        .addr_lsb1(addr_lsb1),
        .advance_load_n(advance_load_n),
        .write_select_n(write_select_n),
        .clock_enable_n(clock_enable_n),
        .chip_select1_n(chip_select1_n),
        .chip_select2(chip_select2),
        .chip_select3_n(chip_select3_n),
        .byte_write_n_0(byteWriteN[0]),
        .byte_write_n_1(byteWriteN[1]),
        .byte_write_n_2(byteWriteN[2]),
        .byte_write_n_3(byteWriteN[3]),
        .dataIn(dataIn),
        .dataOut(dataOut),
        .dataOe_n(dataOe_n),
        .output_drive_n(output_drive_n),
        .sleep_request(sleep_request),
        .burstOrderSelect(burstOrderSelect),
        .sleepActive(sleepActive)
    );

    sram_ctrl_model ctl_u (
        .clk_sys(clk_sys),
        .addrHigh(addrHigh),
        .addr_lsb0(addr_lsb0),
        .addr_lsb1(addr_lsb1),
        .advance_load_n(advance_load_n),
        .write_select_n(write_select_n),
        .clock_enable_n(clock_enable_n),
        .chip_select1_n(chip_select1_n),
        .chip_select2(chip_select2),
        .chip_select3_n(chip_select3_n),
        .byteWriteN(byteWriteN),
        .dataIn(dataIn),
        .dataOut(dataOut),
        .dataOe_n(dataOe_n),
        .output_drive_n(output_drive_n),
        .sleep_request(sleep_request),
        .burstOrderSelect(burstOrderSelect)
    );

    // Compare and count
    task automatic check(input logic [35:0] seen, input logic [35:0] exp,
            input string what);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h",
                $time, what, seen, exp);
        end
    endtask

    // Counts, verdict and end of run
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One cycle: check the previous answer, then track the new command
    task automatic op(input logic [2:0] kind, input logic [17:0] addr,
            input logic [3:0] ben, input logic [35:0] wd,
            input logic [2:0] dsel);
        logic [17:0] a;
        logic moves;
        ctl_u.issue(kind, addr, ben, wd, dsel);
        check({35'h0, ctl_u.obsOe_n}, {35'h0, ~expValid}, "drive");
        if (expValid)
            check(ctl_u.obsData, expData, "read data");
        if (kind != STL)
            expValid = 1'b0;
        if (kind == DES)
            burstOn = 1'b0;
        moves = !asleep && (kind == ADV) && burstOn;
        if (!asleep && (kind == RD || kind == WR)) begin
            burstOn = 1'b1;
            burstWr = (kind == WR);
            burstAddr = addr;
            beat = 2'h0;
            moves = 1'b1;
        end else if (moves)
            beat = beat + 2'h1;
        a = burstAddr;
        a[1:0] = burstOrderSelect ? a[1:0] ^ beat : a[1:0] + beat;
        if (moves && burstWr) begin
            for (int l = 0; l < 4; l++)
                if (!ben[l])
                    mem[a][9*l +: 9] = wd[9*l +: 9];
        end else if (moves) begin
            expValid = 1'b1;
            expData = mem[a];
        end
    endtask

    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            final_report();
        end
    end

    initial begin
        {err_total, checked, cycles} = '0;
        {expValid, burstOn, burstWr, asleep, beat} = '0;
        expData = 36'h000000000;
        burstAddr = 18'h00000;
        rst = 1'b1;
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        check(dataOut, 36'h0, "reset data");
        check({34'h0, dataOe_n, sleepActive}, 36'h2, "reset pins");
        // Whole word, then each lane alone, each read straight back
        op(WR, 18'h00010, 4'h0, 36'h123456789, 3'h0);
        op(RD, 18'h00010, 4'h0, 36'h0, 3'h0);
        for (int l = 0; l < 4; l++) begin
            op(WR, 18'h00010, ~(4'h1 << l), 36'h0a5a5a5a5 + l, 3'h0);
            op(RD, 18'h00010, 4'h0, 36'h0, 3'h0);
        end
        $display("Test done: lane writes");
        // Linear burst write from offset 2, stalled once, then reads
        ctl_u.burstOrderSelect = 1'b0;
        repeat (3) op(STL, 18'h0, 4'h0, 36'h0, 3'h0);
        op(WR, 18'h00122, 4'h0, 36'h111111111, 3'h0);
        for (int b = 1; b < 4; b++) begin
            if (b == 2)
                op(STL, 18'h0, 4'h0, 36'h0, 3'h0);
            op(ADV, 18'h3ffff, 4'h0, 36'h111111111 * (b + 1), 3'h0);
        end
        for (int i = 0; i < 4; i++)
            op(RD, 18'h00120 | 18'(i), 4'h0, 36'h0, 3'h0);
        $display("Test done: linear burst");
        // Interleaved burst read from offset 1, stalled once
        ctl_u.burstOrderSelect = 1'b1;
        repeat (3) op(STL, 18'h0, 4'h0, 36'h0, 3'h0);
        op(RD, 18'h00121, 4'h0, 36'h0, 3'h0);
        for (int b = 1; b < 4; b++) begin
            if (b == 2)
                op(STL, 18'h0, 4'h0, 36'h0, 3'h0);
            op(ADV, 18'h00000, 4'h0, 36'h0, 3'h0);
        end
        $display("Test done: interleaved burst");
        // Each select alone ends a burst; the pending read completes
        for (int d = 0; d < 3; d++) begin
            op(RD, 18'h00120, 4'h0, 36'h0, 3'h0);
            op(ADV, 18'h00000, 4'h0, 36'h0, 3'h0);
            op(DES, 18'h00123, 4'h0, 36'h0, 3'(1 << d));
            op(ADV, 18'h00000, 4'h0, 36'h0, 3'h0);
        end
        $display("Test done: deselect");
        // Output drive pin floats the bus at once, mid-cycle
        op(RD, 18'h00123, 4'h0, 36'h0, 3'h0);
        @(posedge clk_sys);
        #5;
        ctl_u.output_drive_n = 1'b1;
        #1;
        check({35'h0, dataOe_n}, 36'h1, "drive off");
        ctl_u.output_drive_n = 1'b0;
        #1;
        check({35'h0, dataOe_n}, 36'h0, "drive on");
        $display("Test done: output drive");
        // Sleep: a write is ignored and the word keeps its value
        ctl_u.sleep_request = 1'b1;
        repeat (4) op(DES, 18'h0, 4'h0, 36'h0, 3'h1);
        check({35'h0, sleepActive}, 36'h1, "sleep on");
        asleep = 1'b1;
        op(WR, 18'h00010, 4'h0, 36'h0ffff0000, 3'h0);
        op(DES, 18'h0, 4'h0, 36'h0, 3'h1);
        ctl_u.sleep_request = 1'b0;
        repeat (4) op(DES, 18'h0, 4'h0, 36'h0, 3'h1);
        asleep = 1'b0;
        check({35'h0, sleepActive}, 36'h0, "sleep off");
        op(RD, 18'h00010, 4'h0, 36'h0, 3'h0);
        op(DES, 18'h0, 4'h0, 36'h0, 3'h1);
        $display("Test done: sleep");
        final_report();
    end
endmodule
`default_nettype wire
